//--- pkg/crt_timing_map.svh
`ifndef CRT_TIMING_MAP_SVH
`define CRT_TIMING_MAP_SVH

// indices of the indirect register file, selected through the pointer
`define IDX_HORIZONTAL_TOTAL   5'h00
`define IDX_HORIZONTAL_DISP    5'h01
`define IDX_HSYNC_POSITION     5'h02
`define IDX_SYNC_WIDTH         5'h03
`define IDX_VERTICAL_TOTAL     5'h04
`define IDX_VTOTAL_ADJUST      5'h05
`define IDX_VERTICAL_DISP      5'h06
`define IDX_VSYNC_POSITION     5'h07
`define IDX_INTERLACE_MODE     5'h08
`define IDX_MAX_SCAN_LINE      5'h09
`define IDX_CURSOR_START       5'h0A
`define IDX_CURSOR_END         5'h0B
`define IDX_START_ADDR_HI      5'h0C
`define IDX_START_ADDR_LO      5'h0D
`define IDX_CURSOR_ADDR_HI     5'h0E
`define IDX_CURSOR_ADDR_LO     5'h0F
`define IDX_LIGHT_PEN_HI       5'h10
`define IDX_LIGHT_PEN_LO       5'h11

// field positions
`define HS_WIDTH_MSB           3
`define BLINK_MODE_MSB         6
`define BLINK_MODE_LSB         5
`define MODE_VIDEO_BIT         1
`define MODE_INTERLACE_BIT     0
`define ADDR_HI_MSB            5

// reset values of the control registers (only system reset touches them)
`define CTRL_RESET_VALUE       8'h00
`define ADDR_RESET_VALUE       14'h0000

// timing counts
`define VSYNC_SCAN_LINES       5'h10
`define TEST_COUNTER_WIDTH     7
`define BLINK_FAST_BIT         3
`define BLINK_SLOW_BIT         4

`endif

//--- pkg/crt_timing_pkg.sv
package crt_timing_pkg;

	// vertical sequencing: character rows, then extra adjust scan lines
	typedef enum logic [0:0] {
		PH_ROWS   = 1'b0,
		PH_ADJUST = 1'b1
	} vPhase_t;

	// one sample of every pin that arrives from outside this clock domain
	typedef struct packed {
		logic       charClk;
		logic       resetN;
		logic       lightPenStrobe;
		logic       busEnable;
		logic       chipSelectN;
		logic       registerSelect;
		logic       readWriteN;
		logic [7:0] data;
	} pinSample_t;

	// programmable register file
	typedef struct packed {
		logic [4:0]  pointer;
		logic [7:0]  horizontalTotal;
		logic [7:0]  horizontalDisp;
		logic [7:0]  hSyncPosition;
		logic [7:0]  syncWidth;
		logic [6:0]  verticalTotal;
		logic [4:0]  vTotalAdjust;
		logic [6:0]  verticalDisp;
		logic [6:0]  vSyncPosition;
		logic [5:0]  interlaceMode;
		logic [4:0]  maxScanLine;
		logic [6:0]  cursorStart;
		logic [4:0]  cursorEnd;
		logic [13:0] startAddress;
		logic [13:0] cursorAddress;
		logic [13:0] lightPen;
	} regFile_t;

	// video outputs that travel together toward the monitor side
	typedef struct packed {
		logic [13:0] refreshAddress;
		logic [4:0]  rowAddress;
		logic        hSync;
		logic        vSync;
		logic        displayWindow;
		logic        cursor;
	} videoOut_t;

	// whole state of the controller
	typedef struct packed {
		pinSample_t  sync1;
		pinSample_t  sync2;
		pinSample_t  sync3;
		regFile_t    regs;
		videoOut_t   video;
		logic [7:0]  hCount;
		logic [3:0]  hsRemain;
		logic [4:0]  raster;
		logic [6:0]  row;
		logic [4:0]  adjCount;
		logic [4:0]  vsRemain;
		vPhase_t     phase;
		logic [13:0] lineStart;
		logic [13:0] memAddr;
		logic        field;
		logic [4:0]  blinkCount;
		logic        firstFrameDone;
		logic        penPending;
		logic [7:0]  dataOut;
		logic        dataOe;
	} state_t;

endpackage

//--- hdl/crt_raster_timing_controller.sv
`timescale 1ns/1ps
// Behaviour
// - drive 14-bit refresh address over 16K
// - five-bit row address from raster count
// - counters keep running through vertical retrace
// - active-high cursor at valid cursor address
// - timing acts on falling character clock
// - light-pen rising edge captures refresh address
// - light-pen register readable by processor
// - reset low clears counters, keeps registers
// - horizontal sync undefined before position programmed
// - reset with strobe high: test counters
// - addresses go low next falling edge
// - resume at once; enables wait one frame
// - horizontal comparators make sync and window
// - line end advances raster, then rows
// - vertical comparators make sync and window
// - adjust lines lengthen each frame
// - same addresses repeat per scan line
// - start address sets first frame address
// - pointer at select low, data otherwise
// - horizontal total plus one characters period
// - horizontal in characters, vertical in character rows
// - display window only in active area
// - sync width 1..15, zero suppresses sync
// - cursor when cursor register matches address
`include "crt_timing_map.svh"

module crt_raster_timing_controller
	import crt_timing_pkg::*;
(
	input  wire logic        ref_clk,             // system clock, 200 MHz
	input  wire logic        rst,                 // system reset, async high
	input  wire logic        charClkPin,          // character clock from dot counter
	input  wire logic        resetPinN,           // device reset pin, active low
	input  wire logic        light_pen_strobe,    // light pen strobe pin
	input  wire logic        busEnable,           // processor bus enable
	input  wire logic        chipSelectN,         // chip select, active low
	input  wire logic        register_select,     // 0 pointer, 1 data
	input  wire logic        readWriteN,          // 1 read, 0 write
	input  wire logic [7:0]  dataIn,              // data bus input
	output logic      [7:0]  dataOut,             // data bus output
	output logic             dataOe,              // data bus output enable
	output logic      [13:0] refresh_address,     // refresh memory address
	output logic      [4:0]  row_address,         // character row scan line
	output logic             horizontal_sync_out, // horizontal sync
	output logic             vertical_sync_out,   // vertical sync
	output logic             display_window_out,  // display enable
	output logic             match_compare        // cursor output
);

	state_t     s_q;     // registered state
	state_t     s_d;     // next state
	pinSample_t pinsRaw; // unsynchronised pin bundle

	// readable registers only: cursor and light pen, others read zero
	function automatic logic [7:0] regRead(input logic [4:0] idx, input regFile_t r);
		case (idx)
			`IDX_CURSOR_ADDR_HI: regRead = {2'h0, r.cursorAddress[13:8]};
			`IDX_CURSOR_ADDR_LO: regRead = r.cursorAddress[7:0];
			`IDX_LIGHT_PEN_HI:   regRead = {2'h0, r.lightPen[13:8]};
			`IDX_LIGHT_PEN_LO:   regRead = r.lightPen[7:0];
			default:             regRead = 8'h00;
		endcase
	endfunction

	// gather the asynchronous pins into one bundle for the synchroniser
	assign pinsRaw = '{charClk: charClkPin, resetN: resetPinN,
		lightPenStrobe: light_pen_strobe, busEnable: busEnable,
		chipSelectN: chipSelectN, registerSelect: register_select,
		readWriteN: readWriteN, data: dataIn};

	// next-state logic for the whole controller
	always_comb begin
		logic        charTick;    // falling edge of character clock
		logic        busStrobe;   // falling edge of bus enable
		logic        penRise;     // rising edge of light pen strobe
		logic        lineEnd;     // last character of a scan line
		logic        rowEnd;      // last scan line of a character row
		logic        frameEnd;    // last scan line of the frame
		logic        videoMode;   // interlace sync and video mode
		logic [5:0]  rasterNext;  // raster plus step, one bit wider
		logic [4:0]  rasterStart; // first raster of a row in this field
		logic        hWin;        // horizontal display window
		logic        vWin;        // vertical display window
		logic        cursorRange; // raster inside cursor lines
		logic        blinkOn;     // blink phase lets cursor through
		logic [3:0]  hsWidth;     // programmed sync width
		charTick    = 1'b0;
		busStrobe   = 1'b0;
		penRise     = 1'b0;
		lineEnd     = 1'b0;
		rowEnd      = 1'b0;
		frameEnd    = 1'b0;
		videoMode   = 1'b0;
		rasterNext  = 6'h00;
		rasterStart = 5'h00;
		hWin        = 1'b0;
		vWin        = 1'b0;
		cursorRange = 1'b0;
		blinkOn     = 1'b0;
		hsWidth     = 4'h0;
		s_d = s_q;

		// two-stage synchroniser, third stage only for edge detection
		s_d.sync1 = pinsRaw;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		charTick  = s_q.sync3.charClk & ~s_q.sync2.charClk;
		busStrobe = s_q.sync3.busEnable & ~s_q.sync2.busEnable;
		penRise   = ~s_q.sync3.lightPenStrobe & s_q.sync2.lightPenStrobe;

		// processor interface runs on the bus strobe, not the character clock
		if (busStrobe && !s_q.sync2.chipSelectN && !s_q.sync2.readWriteN) begin
			if (!s_q.sync2.registerSelect) begin
				s_d.regs.pointer = s_q.sync2.data[4:0];
			end else begin
				// data location: write the register the pointer selects
				case (s_q.regs.pointer)
					`IDX_HORIZONTAL_TOTAL: s_d.regs.horizontalTotal = s_q.sync2.data;
					`IDX_HORIZONTAL_DISP:  s_d.regs.horizontalDisp = s_q.sync2.data;
					`IDX_HSYNC_POSITION:   s_d.regs.hSyncPosition = s_q.sync2.data;
					`IDX_SYNC_WIDTH:       s_d.regs.syncWidth = s_q.sync2.data;
					`IDX_VERTICAL_TOTAL:   s_d.regs.verticalTotal = s_q.sync2.data[6:0];
					`IDX_VTOTAL_ADJUST:    s_d.regs.vTotalAdjust = s_q.sync2.data[4:0];
					`IDX_VERTICAL_DISP:    s_d.regs.verticalDisp = s_q.sync2.data[6:0];
					`IDX_VSYNC_POSITION:   s_d.regs.vSyncPosition = s_q.sync2.data[6:0];
					`IDX_INTERLACE_MODE:   s_d.regs.interlaceMode = s_q.sync2.data[5:0];
					`IDX_MAX_SCAN_LINE:    s_d.regs.maxScanLine = s_q.sync2.data[4:0];
					`IDX_CURSOR_START:     s_d.regs.cursorStart = s_q.sync2.data[6:0];
					`IDX_CURSOR_END:       s_d.regs.cursorEnd = s_q.sync2.data[4:0];
					`IDX_START_ADDR_HI:
						s_d.regs.startAddress[13:8] = s_q.sync2.data[`ADDR_HI_MSB:0];
					`IDX_START_ADDR_LO:    s_d.regs.startAddress[7:0] = s_q.sync2.data;
					`IDX_CURSOR_ADDR_HI:
						s_d.regs.cursorAddress[13:8] = s_q.sync2.data[`ADDR_HI_MSB:0];
					`IDX_CURSOR_ADDR_LO:   s_d.regs.cursorAddress[7:0] = s_q.sync2.data;
					// light pen and unused indices ignore writes
					default: ;
				endcase
			end
		end

		// read path: drive only while a selected data read is in progress
		s_d.dataOut = regRead(s_q.regs.pointer, s_q.regs);
		s_d.dataOe  = s_q.sync2.busEnable & ~s_q.sync2.chipSelectN
			& s_q.sync2.registerSelect & s_q.sync2.readWriteN;

		// light pen edge is held pending until the next character tick
		if (penRise && s_q.sync2.resetN) begin
			s_d.penPending = 1'b1;
		end

		if (!s_q.sync2.resetN) begin
			// device reset pin low: registers are left alone
			s_d.penPending = 1'b0;
			if (charTick) begin
				s_d.hCount         = 8'h00;
				s_d.hsRemain       = 4'h0;
				s_d.raster         = 5'h00;
				s_d.row            = 7'h00;
				s_d.adjCount       = 5'h00;
				s_d.vsRemain       = 5'h00;
				s_d.phase          = PH_ROWS;
				s_d.lineStart      = s_q.regs.startAddress;
				s_d.field          = 1'b0;
				s_d.firstFrameDone = 1'b0;
				s_d.video          = '0;
				if (s_q.sync2.lightPenStrobe) begin
					// test mode: two independent halves that both count
					s_d.memAddr[`TEST_COUNTER_WIDTH-1:0] =
						s_q.memAddr[`TEST_COUNTER_WIDTH-1:0] + 7'h01;
					s_d.memAddr[13:`TEST_COUNTER_WIDTH] =
						s_q.memAddr[13:`TEST_COUNTER_WIDTH] + 7'h01;
					s_d.video.refreshAddress = s_d.memAddr;
				end else begin
					s_d.memAddr = 14'h0000;
				end
			end
		end else if (charTick) begin
			// mode decode and raster stepping; video mode steps by two
			videoMode   = s_q.regs.interlaceMode[`MODE_VIDEO_BIT]
				& s_q.regs.interlaceMode[`MODE_INTERLACE_BIT];
			rasterStart = videoMode ? {4'h0, s_q.field} : 5'h00;
			rasterNext  = {1'b0, s_q.raster} + (videoMode ? 6'h02 : 6'h01);
			lineEnd     = (s_q.hCount == s_q.regs.horizontalTotal);
			rowEnd      = (rasterNext > {1'b0, s_q.regs.maxScanLine});

			// latch the address the pen saw, taken on the character clock
			if (s_q.penPending) begin
				s_d.regs.lightPen = s_q.memAddr;
				s_d.penPending    = penRise;
			end

			// horizontal counter and address walk
			s_d.hCount  = lineEnd ? 8'h00 : s_q.hCount + 8'h01;
			s_d.memAddr = s_q.memAddr + 14'h0001;

			if (lineEnd) begin
				// vertical sync counts down once per scan line
				if (s_q.vsRemain != 5'h00) begin
					s_d.vsRemain = s_q.vsRemain - 5'h01;
				end
				case (s_q.phase)
					PH_ROWS: begin
						if (rowEnd) begin
							if (s_q.row == s_q.regs.verticalTotal) begin
								if (s_q.regs.vTotalAdjust != 5'h00) begin
									s_d.phase    = PH_ADJUST;
									s_d.adjCount = 5'h00;
									s_d.raster   = 5'h00;
								end else begin
									frameEnd = 1'b1;
								end
							end else begin
								s_d.row    = s_q.row + 7'h01;
								s_d.raster = rasterStart;
							end
						end else begin
							s_d.raster = rasterNext[4:0];
						end
					end
					PH_ADJUST: begin
						// extra scan lines; raster keeps counting for refresh
						s_d.raster = s_q.raster + 5'h01;
						if (s_q.adjCount + 5'h01 == s_q.regs.vTotalAdjust) begin
							frameEnd = 1'b1;
						end else begin
							s_d.adjCount = s_q.adjCount + 5'h01;
						end
					end
					default: s_d.phase = PH_ROWS;
				endcase

				// choose where the next scan line starts in memory
				if (frameEnd) begin
					s_d.phase          = PH_ROWS;
					s_d.row            = 7'h00;
					s_d.field          = s_q.regs.interlaceMode[`MODE_INTERLACE_BIT]
						& ~s_q.field;
					s_d.raster         = videoMode ? {4'h0, s_d.field} : 5'h00;
					s_d.lineStart      = s_q.regs.startAddress;
					s_d.firstFrameDone = 1'b1;
					s_d.blinkCount     = s_q.blinkCount + 5'h01;
				end else if (s_q.phase == PH_ROWS && rowEnd) begin
					s_d.lineStart = s_q.lineStart + {6'h00, s_q.regs.horizontalDisp};
				end
				s_d.memAddr = s_d.lineStart;

				// vertical sync starts as the programmed row begins
				if (s_q.phase == PH_ROWS && rowEnd && !frameEnd
					&& s_d.row == s_q.regs.vSyncPosition) begin
					s_d.vsRemain = `VSYNC_SCAN_LINES;
				end else if (frameEnd && s_q.regs.vSyncPosition == 7'h00) begin
					s_d.vsRemain = `VSYNC_SCAN_LINES;
				end
			end

			// horizontal sync: undefined until its position is written
			hsWidth = s_q.regs.syncWidth[`HS_WIDTH_MSB:0];
			if (s_d.hCount == s_q.regs.hSyncPosition && hsWidth != 4'h0) begin
				s_d.hsRemain = hsWidth;
			end else if (s_q.hsRemain != 4'h0) begin
				s_d.hsRemain = s_q.hsRemain - 4'h1;
			end

			// display windows for the character now being addressed
			hWin = (s_d.hCount < s_q.regs.horizontalDisp);
			vWin = (s_d.phase == PH_ROWS) && (s_d.row < s_q.regs.verticalDisp);

			// cursor line range and blink gate
			cursorRange = (s_d.raster >= s_q.regs.cursorStart[4:0])
				&& (s_d.raster <= s_q.regs.cursorEnd);
			case (s_q.regs.cursorStart[`BLINK_MODE_MSB:`BLINK_MODE_LSB])
				2'h0:    blinkOn = 1'b1;
				2'h1:    blinkOn = 1'b0;
				2'h2:    blinkOn = s_q.blinkCount[`BLINK_FAST_BIT];
				default: blinkOn = s_q.blinkCount[`BLINK_SLOW_BIT];
			endcase

			// outputs are registered copies of the new counters
			s_d.video.refreshAddress = s_d.memAddr;
			s_d.video.rowAddress     = s_d.raster;
			s_d.video.hSync          = (s_d.hsRemain != 4'h0);
			s_d.video.vSync          = (s_d.vsRemain != 5'h00);
			s_d.video.displayWindow  = hWin & vWin & s_d.firstFrameDone;
			s_d.video.cursor         = hWin & vWin & s_d.firstFrameDone & blinkOn
				& cursorRange & (s_d.memAddr == s_q.regs.cursorAddress);
		end
	end

	// single register stage; system reset is the only thing that clears registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q       <= '0;
			s_q.phase <= PH_ROWS;
		end else begin
			s_q <= s_d;
		end
	end

	// every output is a field of the registered state
	assign dataOut             = s_q.dataOut;
	assign dataOe              = s_q.dataOe;
	assign refresh_address     = s_q.video.refreshAddress;
	assign row_address         = s_q.video.rowAddress;
	assign horizontal_sync_out = s_q.video.hSync;
	assign vertical_sync_out   = s_q.video.vSync;
	assign display_window_out  = s_q.video.displayWindow;
	assign match_compare       = s_q.video.cursor;

endmodule // crt_raster_timing_controller

//--- dv/crt_raster_timing_controller_sva.sv
`timescale 1ns/1ps
module crt_raster_timing_controller_sva
	import crt_timing_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        charClkPin,
	input wire logic        resetPinN,
	input wire logic        light_pen_strobe,
	input wire logic        chipSelectN,
	input wire logic        register_select,
	input wire logic        readWriteN,
	input wire logic        dataOe,
	input wire logic [13:0] refresh_address,
	input wire logic [4:0]  row_address,
	input wire logic        horizontal_sync_out,
	input wire logic        vertical_sync_out,
	input wire logic        display_window_out,
	input wire logic        match_compare
);
	logic       clkSeen_q;  // last sample of the character clock
	logic [3:0] tickAge_q;  // cycles since the last falling character clock
	logic [4:0] lowCount_q; // cycles spent in plain reset mode
	logic       cleared_q;  // reset mode was reached before test mode
	logic [4:0] hsInVs_q;   // horizontal pulses seen inside one vertical pulse

	// helper counters; tickAge_q and lowCount_q saturate so long waits never wrap
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clkSeen_q  <= 1'b0;
			tickAge_q  <= 4'hF;
			lowCount_q <= 5'h00;
			cleared_q  <= 1'b0;
			hsInVs_q   <= 5'h00;
		end else begin
			clkSeen_q  <= charClkPin;
			tickAge_q  <= (clkSeen_q && !charClkPin) ? 4'h0 :
				(tickAge_q == 4'hF ? 4'hF : tickAge_q + 4'h1);
			lowCount_q <= (!resetPinN && !light_pen_strobe) ?
				(lowCount_q == 5'h1F ? 5'h1F : lowCount_q + 5'h01) : 5'h00;
			cleared_q  <= resetPinN ? 1'b0 : (cleared_q || lowCount_q >= 5'h18);
			hsInVs_q   <= (!vertical_sync_out || !resetPinN) ? 5'h00 :
				hsInVs_q + {4'h0, $rose(horizontal_sync_out)};
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// a started horizontal pulse stays high for at least eight system clocks
	sequence hsHold;
		horizontal_sync_out [*8];
	endsequence

	video_on_tick_a: assert property ($changed({refresh_address, row_address,
		horizontal_sync_out, vertical_sync_out, display_window_out, match_compare})
		|-> tickAge_q inside {[1:7]}) else $error("video output moved off a character tick");
	cursor_in_window_a: assert property (match_compare |-> display_window_out)
		else $error("cursor outside the display window");
	reset_clear_a: assert property (lowCount_q >= 5'h18 |-> ({refresh_address, row_address,
		horizontal_sync_out, vertical_sync_out, display_window_out, match_compare} == 23'h0))
		else $error("outputs not low while held in reset");
	test_split_a: assert property ((!resetPinN && light_pen_strobe && cleared_q)
		|-> refresh_address[6:0] == refresh_address[13:7]) else $error("test counters diverged");
	hsync_width_a: assert property (disable iff (rst || !resetPinN)
		$rose(horizontal_sync_out) |-> hsHold) else $error("horizontal pulse too short");
	vsync_lines_a: assert property (disable iff (rst || !resetPinN)
		($fell(vertical_sync_out) && hsInVs_q != 5'h00) |-> hsInVs_q == 5'h10)
		else $error("vertical pulse not sixteen lines");
	bus_drive_a: assert property (dataOe |-> (!$past(chipSelectN, 3) &&
		$past(register_select, 3) && $past(readWriteN, 3))) else $error("data bus driven outside a read");
	retrace_count_a: assert property (disable iff (rst || !resetPinN)
		(vertical_sync_out && refresh_address != 14'h0000) |-> ##[1:40] $changed(refresh_address))
		else $error("refresh address stalled in retrace");
endmodule // crt_raster_timing_controller_sva

bind crt_raster_timing_controller crt_raster_timing_controller_sva u_sva (
	.ref_clk(ref_clk), .rst(rst), .charClkPin(charClkPin), .resetPinN(resetPinN),
	.light_pen_strobe(light_pen_strobe), .chipSelectN(chipSelectN),
	.register_select(register_select), .readWriteN(readWriteN), .dataOe(dataOe),
	.refresh_address(refresh_address), .row_address(row_address),
	.horizontal_sync_out(horizontal_sync_out), .vertical_sync_out(vertical_sync_out),
	.display_window_out(display_window_out), .match_compare(match_compare)
);

//--- dv/crt_monitor_model.sv
`timescale 1ns/1ps
module crt_monitor_model (
	input  wire logic       ref_clk,
	input  wire logic       clr,
	input  wire logic       hSync,
	input  wire logic       vSync,
	input  wire logic       de,
	input  wire logic       cursor,
	output logic            charClkPin,
	output logic      [7:0] hsPeriod,
	output logic      [7:0] hsWidth,
	output logic      [7:0] lineCount,
	output logic      [7:0] deWidth,
	output logic            deSeen,
	output logic            curSeen,
	output logic            hsSeen
);
	logic [3:0] phase;   // dot counter phase, ten system clocks per character
	logic [7:0] tickCnt; // characters since the last horizontal pulse
	logic [7:0] wCnt;    // length of the running horizontal pulse
	logic [7:0] dCnt;    // length of the running display window
	logic [7:0] lCnt;    // lines since the last vertical pulse
	logic       hsPrev;  // previous sampled levels
	logic       vsPrev;

	initial begin
		{phase, tickCnt, wCnt, dCnt, lCnt, hsPrev, vsPrev} = '0;
		{hsPeriod, hsWidth, lineCount, deWidth, deSeen, curSeen, hsSeen} = '0;
		charClkPin = 1'b1;
	end

	// character clock runs free; outputs sampled 8 clocks after the falling edge,
	// well clear of the synchroniser lag inside the controller
	always @(posedge ref_clk) begin
		phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
		charClkPin <= (phase == 4'h9 || phase < 4'h4);
		if (clr) begin
			{deSeen, curSeen, hsSeen} <= 3'b000;
		end else if (phase == 4'h2) begin
			hsPrev  <= hSync;
			vsPrev  <= vSync;
			tickCnt <= tickCnt + 8'h01;
			wCnt    <= hSync ? wCnt + 8'h01 : 8'h00;
			dCnt    <= de ? dCnt + 8'h01 : 8'h00;
			deSeen  <= deSeen | de;
			curSeen <= curSeen | cursor;
			if (hSync && !hsPrev) begin
				hsPeriod <= tickCnt + 8'h01;
				tickCnt  <= 8'h00;
				lCnt     <= lCnt + 8'h01;
				hsSeen   <= 1'b1;
			end
			if (!hSync && hsPrev) hsWidth <= wCnt;
			if (!de && dCnt != 8'h00) deWidth <= dCnt;
			if (vSync && !vsPrev) begin
				lineCount <= lCnt;
				lCnt      <= 8'h00;
			end
		end
	end
endmodule // crt_monitor_model

//--- dv/crt_raster_timing_controller_test.sv
`timescale 1ns/1ps
`include "crt_timing_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module crt_raster_timing_controller_test
	import crt_timing_pkg::*;
;
	logic        ref_clk, rst, resetPinN, light_pen_strobe, busEnable, clr;
	logic        chipSelectN, register_select, readWriteN, charClkPin, dataOe;
	logic [7:0]  dataIn, dataOut, rdData, hsPeriod, hsWidth, lineCount, deWidth;
	logic [13:0] refresh_address;
	logic [4:0]  row_address;
	logic        horizontal_sync_out, vertical_sync_out, display_window_out, match_compare;
	logic        deSeen, curSeen, hsSeen;
	logic [7:0]  progVal [16]; // values for indices 0..15
	int          err_count, compares, cycles;

	crt_raster_timing_controller dut (.ref_clk(ref_clk), .rst(rst), .charClkPin(charClkPin),
		.resetPinN(resetPinN), .light_pen_strobe(light_pen_strobe), .busEnable(busEnable),
		.chipSelectN(chipSelectN), .register_select(register_select), .readWriteN(readWriteN),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .refresh_address(refresh_address),
		.row_address(row_address), .horizontal_sync_out(horizontal_sync_out),
		.vertical_sync_out(vertical_sync_out), .display_window_out(display_window_out),
		.match_compare(match_compare));
	crt_monitor_model mon (.ref_clk(ref_clk), .clr(clr), .hSync(horizontal_sync_out),
		.vSync(vertical_sync_out), .de(display_window_out), .cursor(match_compare),
		.charClkPin(charClkPin), .hsPeriod(hsPeriod), .hsWidth(hsWidth), .lineCount(lineCount),
		.deWidth(deWidth), .deSeen(deSeen), .curSeen(curSeen), .hsSeen(hsSeen));

	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;

	// hang guard, about twice the planned run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one processor cycle: select first, enable held 5 clocks, select held past its fall
	task automatic busCycle(input logic rs, input logic rw, input logic [7:0] d);
		@(posedge ref_clk);
		chipSelectN <= 1'b0;
		register_select <= rs;
		readWriteN <= rw;
		dataIn <= d;
		@(posedge ref_clk);
		busEnable <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rdData = dataOut;
		busEnable <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chipSelectN <= 1'b1;
		readWriteN <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [4:0] idx, input logic [7:0] val);
		busCycle(1'b0, 1'b0, {3'h0, idx});
		busCycle(1'b1, 1'b0, val);
	endtask

	task automatic chkReg(input logic [4:0] idx, input logic [7:0] exp);
		busCycle(1'b0, 1'b0, {3'h0, idx});
		busCycle(1'b1, 1'b1, 8'h00);
		`CHK(rdData, exp)
	endtask

	// park just after a vertical pulse so later work stays clear of the next one
	task automatic waitVsEnd();
		int i;
		i = 0;
		while (!vertical_sync_out && i < 3000) begin @(posedge ref_clk); i++; end
		while (vertical_sync_out && i < 6000) begin @(posedge ref_clk); i++; end
		if (i >= 6000) err_count++;
	endtask

	initial begin
		{rst, resetPinN} = 2'b10; // device held in reset while it is programmed
		{light_pen_strobe, busEnable, clr, register_select} = 4'h0;
		{chipSelectN, readWriteN} = 2'b11;
		dataIn = 8'h00;
		{err_count, compares, cycles} = 0;
		// 10 chars a line, 4 shown; 10 rows of 2 lines plus 3 adjust; start 2A00
		progVal = '{8'h09, 8'h04, 8'h06, 8'h02, 8'h09, 8'h03, 8'h03, 8'h05,
			8'h00, 8'h01, 8'h00, 8'h01, 8'h2A, 8'h00, 8'h2A, 8'h06};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 16; i++) wr(i[4:0], progVal[i]);
		chkReg(`IDX_CURSOR_ADDR_HI, 8'h2A);
		chkReg(`IDX_CURSOR_ADDR_LO, 8'h06);
		chkReg(`IDX_HORIZONTAL_TOTAL, 8'h00);
		wr(5'h12, 8'h55); // unmapped index, must be ignored
		chkReg(5'h12, 8'h00);
		// release only now so no half-programmed frame reaches the checks
		resetPinN <= 1'b1;
		repeat (7000) @(posedge ref_clk);
		`CHK(hsPeriod, 8'h0A)
		`CHK(hsWidth, 8'h02)
		`CHK(lineCount, 8'h17)
		`CHK(deWidth, 8'h04)
		`CHK(curSeen, 1'b1)
		// light pen: every address of the frame lies in 2A00..2A31
		light_pen_strobe <= 1'b1;
		repeat (20) @(posedge ref_clk);
		light_pen_strobe <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chkReg(`IDX_LIGHT_PEN_HI, 8'h2A);
		wr(`IDX_LIGHT_PEN_HI, 8'h11); // read-only, write dropped
		chkReg(`IDX_LIGHT_PEN_HI, 8'h2A);
		busCycle(1'b0, 1'b0, {3'h0, `IDX_LIGHT_PEN_LO});
		busCycle(1'b1, 1'b1, 8'h00);
		`CHK(rdData <= 8'h31, 1'b1)
		`CHK(rdData[7:6], 2'b00)
		// zero width suppresses the horizontal pulse
		waitVsEnd();
		wr(`IDX_SYNC_WIDTH, 8'h00);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (300) @(posedge ref_clk);
		`CHK(hsSeen, 1'b0)
		wr(`IDX_SYNC_WIDTH, 8'h02);
		// device reset held 40 clocks, longer than one character period
		resetPinN <= 1'b0;
		repeat (40) @(posedge ref_clk);
		`CHK({refresh_address, row_address, horizontal_sync_out, vertical_sync_out, display_window_out, match_compare}, 23'h0)
		light_pen_strobe <= 1'b1;
		repeat (200) @(posedge ref_clk);
		`CHK(refresh_address[6:0], refresh_address[13:7])
		`CHK(refresh_address != 14'h0000, 1'b1)
		light_pen_strobe <= 1'b0;
		repeat (40) @(posedge ref_clk);
		resetPinN <= 1'b1;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (2000) @(posedge ref_clk);
		`CHK(deSeen, 1'b0)
		`CHK(curSeen, 1'b0)
		`CHK(hsSeen, 1'b1)
		repeat (7000) @(posedge ref_clk);
		`CHK(hsPeriod, 8'h0A)
		`CHK(deSeen, 1'b1)
		`CHK(curSeen, 1'b1)
		// blink held off: the cursor must stay dark for a whole frame
		wr(`IDX_CURSOR_START, 8'h20);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (2500) @(posedge ref_clk);
		`CHK(curSeen, 1'b0)
		`CHK(deSeen, 1'b1)
		end_of_test();
	end
endmodule // crt_raster_timing_controller_test
